// ==== hw/timer2_pkg.sv ====
// package of constants and types for the reload/capture timer
package timer2_pkg;

  // bus widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  // register byte addresses
  localparam logic [7:0] OFF_CONTROL     = 8'hc8;
  localparam logic [7:0] OFF_COUNT_LOW   = 8'hcc;
  localparam logic [7:0] OFF_COUNT_HIGH  = 8'hd0;
  localparam logic [7:0] OFF_RELOAD_LOW  = 8'hd4;
  localparam logic [7:0] OFF_RELOAD_HIGH = 8'hd8;
  localparam logic [7:0] OFF_CLOCK_SEL   = 8'hdc;
  localparam logic [7:0] OFF_IRQ_ENABLE  = 8'he0;
  localparam logic [7:0] OFF_IRQ_STATUS  = 8'he4;
  localparam logic [7:0] OFF_IRQ_MASK    = 8'he8;

  // reset values and byte maximum
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [2:0] RST_EVENTS = 3'h0;
  localparam logic [7:0] BYTE_MAX = 8'hff;

  // clock select register fields
  localparam int CKSEL_LOW_BIT = 0;
  localparam int CKSEL_HIGH_BIT = 1;
  // irq enable register field
  localparam int IE_TIMER_BIT = 0;
  // event status / mask field positions
  localparam int EV_HIGH_OVF = 0;
  localparam int EV_LOW_OVF = 1;
  localparam int EV_CAPTURE = 2;
  localparam int EV_W = 3;

  // clock dividers
  localparam int DIV_SYS = 12;
  localparam int DIV_EXT = 8;
  localparam logic [3:0] DIV_SYS_LAST = 4'(DIV_SYS - 1);
  localparam logic [2:0] DIV_EXT_LAST = 3'(DIV_EXT - 1);

  // control register layout, bit 7 down to bit 0
  typedef struct packed {
    logic high_overflow_flag;
    logic low_overflow_flag;
    logic low_byte_irq_enable;
    logic capture_enable;
    logic split_mode;
    logic run_bit;
    logic unused_bit;
    logic external_clock_select;
  } ctrl_s;

  // register bus request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } bus_req_s;

endpackage : timer2_pkg

// ==== hw/timer2_reload_capture.sv ====
// reload/capture timer: 16-bit or split 8-bit auto-reload, comparator capture
//
// Our own choice: the strobed register port.
`timescale 1ns/1ps
module timer2_reload_capture (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // register bus
  input wire timer2_pkg::bus_req_s i_bus,
  output logic [timer2_pkg::DATA_W-1:0] o_rdata,
  // asynchronous inputs from outside the clock domain
  input wire logic i_ext_osc,
  input wire logic i_cmp_out,
  // interrupt
  output logic o_irq
);
  import timer2_pkg::*;

  // address compare used by every register
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  ctrl_s ctrl_r;
  logic [7:0] cnt_lo_r;
  logic [7:0] cnt_hi_r;
  logic [7:0] rl_lo_r;
  logic [7:0] rl_hi_r;
  logic [1:0] cksel_r;
  logic ie_r;
  logic [EV_W-1:0] status_r;
  logic [EV_W-1:0] mask_r;
  logic [3:0] div_sys_r;
  logic div_sys_tick_r;
  logic [2:0] div_ext_r;
  logic ext_tick_r;
  logic ext_s1_r;
  logic ext_s2_r;
  logic ext_s3_r;
  logic ext_lvl_r;
  logic cmp_s1_r;
  logic cmp_s2_r;
  logic cmp_s3_r;
  logic cmp_lvl_r;
  logic cmp_rise_r;

  // write strobes per register
  logic wr_ctrl;
  logic wr_lo;
  logic wr_hi;
  logic wr_rl_lo;
  logic wr_rl_hi;
  logic wr_cksel;
  logic wr_ie;
  logic wr_st;
  logic wr_mask;

  always_comb begin
    wr_ctrl = i_bus.wr && hit(i_bus.addr, OFF_CONTROL);
    wr_lo = i_bus.wr && hit(i_bus.addr, OFF_COUNT_LOW);
    wr_hi = i_bus.wr && hit(i_bus.addr, OFF_COUNT_HIGH);
    wr_rl_lo = i_bus.wr && hit(i_bus.addr, OFF_RELOAD_LOW);
    wr_rl_hi = i_bus.wr && hit(i_bus.addr, OFF_RELOAD_HIGH);
    wr_cksel = i_bus.wr && hit(i_bus.addr, OFF_CLOCK_SEL);
    wr_ie = i_bus.wr && hit(i_bus.addr, OFF_IRQ_ENABLE);
    wr_st = i_bus.wr && hit(i_bus.addr, OFF_IRQ_STATUS);
    wr_mask = i_bus.wr && hit(i_bus.addr, OFF_IRQ_MASK);
  end

  // system clock divided by 12, one-cycle enable
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      div_sys_r <= 4'h0;
      div_sys_tick_r <= 1'b0;
    end else begin
      div_sys_tick_r <= (div_sys_r == DIV_SYS_LAST);
      div_sys_r <= (div_sys_r == DIV_SYS_LAST) ? 4'h0 : div_sys_r + 4'h1;
    end
  end

  // three-stage synchronisers; a level counts once stages two and three agree
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      ext_s1_r <= 1'b0;
      ext_s2_r <= 1'b0;
      ext_s3_r <= 1'b0;
      cmp_s1_r <= 1'b0;
      cmp_s2_r <= 1'b0;
      cmp_s3_r <= 1'b0;
    end else begin
      ext_s1_r <= i_ext_osc;
      ext_s2_r <= ext_s1_r;
      ext_s3_r <= ext_s2_r;
      cmp_s1_r <= i_cmp_out;
      cmp_s2_r <= cmp_s1_r;
      cmp_s3_r <= cmp_s2_r;
    end
  end

  // external oscillator divided by 8 on its qualified rising edges
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      ext_lvl_r <= 1'b0;
      div_ext_r <= 3'h0;
      ext_tick_r <= 1'b0;
    end else begin
      ext_tick_r <= 1'b0;
      if (ext_s2_r == ext_s3_r) begin
        ext_lvl_r <= ext_s3_r;
        if (ext_s3_r && !ext_lvl_r) begin
          div_ext_r <= div_ext_r + 3'h1;
          ext_tick_r <= (div_ext_r == DIV_EXT_LAST);
        end
      end
    end
  end

  // comparator rising edge, filtered the same way to avoid glitch captures
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      cmp_lvl_r <= 1'b0;
      cmp_rise_r <= 1'b0;
    end else begin
      cmp_rise_r <= 1'b0;
      if (cmp_s2_r == cmp_s3_r) begin
        cmp_lvl_r <= cmp_s3_r;
        cmp_rise_r <= cmp_s3_r && !cmp_lvl_r;
      end
    end
  end

  // clock selection and count enables
  logic cap_mode;
  logic shared_tick;
  logic tick_lo;
  logic tick_hi;
  logic lo_inc;
  logic hi_inc;
  logic lo_roll;
  logic hi_roll;
  logic cap_event;

  always_comb begin
    cap_mode = ctrl_r.capture_enable && !ctrl_r.split_mode;
    shared_tick = ctrl_r.external_clock_select ? ext_tick_r : div_sys_tick_r;
    if (cap_mode) begin
      tick_lo = cksel_r[CKSEL_LOW_BIT] ? 1'b1 : div_sys_tick_r;
    end else begin
      tick_lo = cksel_r[CKSEL_LOW_BIT] ? 1'b1 : shared_tick;
    end
    tick_hi = cksel_r[CKSEL_HIGH_BIT] ? 1'b1 : shared_tick;
    if (ctrl_r.split_mode) begin
      lo_inc = tick_lo;
      hi_inc = ctrl_r.run_bit && tick_hi;
    end else begin
      lo_inc = ctrl_r.run_bit && tick_lo;
      hi_inc = lo_inc && (cnt_lo_r == BYTE_MAX);
    end
    lo_roll = lo_inc && (cnt_lo_r == BYTE_MAX);
    hi_roll = hi_inc && (cnt_hi_r == BYTE_MAX);
    cap_event = cap_mode && cmp_rise_r;
  end

  // count bytes; a software write to a byte wins over counting it
  logic [7:0] cnt_lo_nxt;
  logic [7:0] cnt_hi_nxt;

  always_comb begin
    cnt_lo_nxt = cnt_lo_r;
    cnt_hi_nxt = cnt_hi_r;
    if (lo_inc) begin
      if (ctrl_r.split_mode && lo_roll) begin
        cnt_lo_nxt = rl_lo_r;
      end else if (!ctrl_r.split_mode && hi_roll && !cap_mode) begin
        cnt_lo_nxt = rl_lo_r;
      end else begin
        cnt_lo_nxt = cnt_lo_r + 8'h01;
      end
    end
    if (hi_inc) begin
      if (hi_roll && (ctrl_r.split_mode || !cap_mode)) begin
        cnt_hi_nxt = rl_hi_r;
      end else begin
        cnt_hi_nxt = cnt_hi_r + 8'h01;
      end
    end
    if (wr_lo) begin
      cnt_lo_nxt = i_bus.wdata;
    end
    if (wr_hi) begin
      cnt_hi_nxt = i_bus.wdata;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      cnt_lo_r <= RST_BYTE;
      cnt_hi_r <= RST_BYTE;
    end else begin
      cnt_lo_r <= cnt_lo_nxt;
      cnt_hi_r <= cnt_hi_nxt;
    end
  end

  // reload bytes; a capture beats a software write in the same cycle
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      rl_lo_r <= RST_BYTE;
      rl_hi_r <= RST_BYTE;
    end else if (cap_event) begin
      rl_lo_r <= cnt_lo_r;
      rl_hi_r <= cnt_hi_r;
    end else begin
      if (wr_rl_lo) begin
        rl_lo_r <= i_bus.wdata;
      end
      if (wr_rl_hi) begin
        rl_hi_r <= i_bus.wdata;
      end
    end
  end

  // control register; hardware only sets flags, and a set beats a write
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      ctrl_r <= ctrl_s'(RST_CONTROL);
    end else begin
      if (wr_ctrl) begin
        ctrl_r <= ctrl_s'(i_bus.wdata);
        ctrl_r.unused_bit <= 1'b0;
      end
      if (lo_roll) begin
        ctrl_r.low_overflow_flag <= 1'b1;
      end else if (wr_ctrl) begin
        ctrl_r.low_overflow_flag <= i_bus.wdata[6];
      end
      if (hi_roll || cap_event) begin
        ctrl_r.high_overflow_flag <= 1'b1;
      end else if (wr_ctrl) begin
        ctrl_r.high_overflow_flag <= i_bus.wdata[7];
      end
    end
  end

  // configuration registers
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      cksel_r <= 2'h0;
      ie_r <= 1'b0;
      mask_r <= RST_EVENTS;
    end else begin
      if (wr_cksel) begin
        cksel_r <= i_bus.wdata[1:0];
      end
      if (wr_ie) begin
        ie_r <= i_bus.wdata[IE_TIMER_BIT];
      end
      if (wr_mask) begin
        mask_r <= i_bus.wdata[EV_W-1:0];
      end
    end
  end

  // sticky event status, write one to clear; a new event wins
  logic [EV_W-1:0] ev_now;
  always_comb begin
    ev_now = RST_EVENTS;
    ev_now[EV_HIGH_OVF] = hi_roll;
    ev_now[EV_LOW_OVF] = lo_roll;
    ev_now[EV_CAPTURE] = cap_event;
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      status_r <= RST_EVENTS;
    end else if (wr_st) begin
      status_r <= (status_r & ~i_bus.wdata[EV_W-1:0]) | ev_now;
    end else begin
      status_r <= status_r | ev_now;
    end
  end

  // interrupt level: timer flags under the global enable, or masked status
  always_comb begin
    o_irq = (ie_r && (ctrl_r.high_overflow_flag
             || (ctrl_r.low_overflow_flag && ctrl_r.low_byte_irq_enable)))
            || |(status_r & mask_r);
  end

  // read data, valid only in the cycle after the strobe; unmapped reads zero
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_rdata <= RST_BYTE;
    end else if (!i_bus.rd) begin
      o_rdata <= RST_BYTE;
    end else if (hit(i_bus.addr, OFF_CONTROL)) begin
      o_rdata <= {ctrl_r[7:2], 1'b0, ctrl_r[0]};
    end else if (hit(i_bus.addr, OFF_COUNT_LOW)) begin
      o_rdata <= cnt_lo_r;
    end else if (hit(i_bus.addr, OFF_COUNT_HIGH)) begin
      o_rdata <= cnt_hi_r;
    end else if (hit(i_bus.addr, OFF_RELOAD_LOW)) begin
      o_rdata <= rl_lo_r;
    end else if (hit(i_bus.addr, OFF_RELOAD_HIGH)) begin
      o_rdata <= rl_hi_r;
    end else if (hit(i_bus.addr, OFF_CLOCK_SEL)) begin
      o_rdata <= {6'h00, cksel_r};
    end else if (hit(i_bus.addr, OFF_IRQ_ENABLE)) begin
      o_rdata <= {7'h00, ie_r};
    end else if (hit(i_bus.addr, OFF_IRQ_STATUS)) begin
      o_rdata <= {5'h00, status_r};
    end else if (hit(i_bus.addr, OFF_IRQ_MASK)) begin
      o_rdata <= {5'h00, mask_r};
    end else begin
      o_rdata <= RST_BYTE;
    end
  end

  // checks on the counting and flag logic
  a_wrap_reload: assert property (@(posedge i_clk) disable iff (i_srst)
    (!ctrl_r.split_mode && !cap_mode && hi_roll && !wr_lo && !wr_hi && !wr_rl_lo
     && !wr_rl_hi) |=> ({cnt_hi_r, cnt_lo_r} == {$past(rl_hi_r), $past(rl_lo_r)}))
    else $error("16-bit wrap did not load reload value");

  a_high_flag_set: assert property (@(posedge i_clk) disable iff (i_srst)
    hi_roll |=> ctrl_r.high_overflow_flag)
    else $error("high rollover did not set high flag");

  a_low_flag_set: assert property (@(posedge i_clk) disable iff (i_srst)
    (lo_inc && cnt_lo_r == BYTE_MAX) |=> ctrl_r.low_overflow_flag)
    else $error("low rollover did not set low flag");

  a_flag_sticky: assert property (@(posedge i_clk) disable iff (i_srst)
    (ctrl_r.high_overflow_flag && !wr_ctrl) |=> ctrl_r.high_overflow_flag)
    else $error("high flag cleared without a write");

  a_capture_copy: assert property (@(posedge i_clk) disable iff (i_srst)
    cap_event |=> (rl_hi_r == $past(cnt_hi_r) && rl_lo_r == $past(cnt_lo_r)
                   && ctrl_r.high_overflow_flag))
    else $error("capture did not copy count");

  a_irq_high: assert property (@(posedge i_clk) disable iff (i_srst)
    (ie_r && ctrl_r.high_overflow_flag) |-> o_irq)
    else $error("irq missing for high flag");

  a_irq_low_gate: assert property (@(posedge i_clk) disable iff (i_srst)
    (!ie_r && (status_r & mask_r) == RST_EVENTS) |-> !o_irq)
    else $error("irq raised while disabled");

  a_irq_low_en: assert property (@(posedge i_clk) disable iff (i_srst)
    (ie_r && ctrl_r.low_byte_irq_enable && ctrl_r.low_overflow_flag) |-> o_irq)
    else $error("irq missing for low flag");

  a_unused_zero: assert property (@(posedge i_clk) disable iff (i_srst)
    (i_bus.rd && hit(i_bus.addr, OFF_CONTROL)) |=> !o_rdata[1])
    else $error("unused control bit read non-zero");

  a_split_run_gate: assert property (@(posedge i_clk) disable iff (i_srst)
    (ctrl_r.split_mode && !ctrl_r.run_bit && !wr_hi) |=> $stable(cnt_hi_r))
    else $error("high byte counted while stopped in split mode");

  a_div_spacing: assert property (@(posedge i_clk) disable iff (i_srst)
    div_sys_tick_r |=> !div_sys_tick_r [*8] ##1 !div_sys_tick_r ##1 !div_sys_tick_r
    ##1 !div_sys_tick_r ##1 div_sys_tick_r)
    else $error("system divide-by-12 enable spacing wrong");

  c_wrap16: cover property (@(posedge i_clk) disable iff (i_srst)
    !ctrl_r.split_mode && hi_roll);
  c_split_low_reload: cover property (@(posedge i_clk) disable iff (i_srst)
    ctrl_r.split_mode && lo_roll);
  c_capture: cover property (@(posedge i_clk) disable iff (i_srst) cap_event);
  c_ext_tick: cover property (@(posedge i_clk) disable iff (i_srst)
    ctrl_r.external_clock_select && ext_tick_r && lo_inc);

endmodule : timer2_reload_capture

// ==== verification/cmp_osc_model.sv ====
// far-side model: free-running external oscillator and comparator output
`timescale 1ns/1ps
module cmp_osc_model (
  // request from the bench for a comparator level
  input wire logic i_cmp_req,
  // pins toward the timer
  output logic o_ext_osc,
  output logic o_cmp_out
);
  // oscillator runs free, 20.6 ns period, no phase tie to the system clock
  initial begin
    o_ext_osc = 1'b0;
    forever #10.3 o_ext_osc = ~o_ext_osc;
  end

  // comparator edges land off the clock grid, as an analog output would;
  // one process owns the pin so it keeps a single driver
  initial begin
    o_cmp_out = 1'b0;
    forever begin
      @(i_cmp_req);
      o_cmp_out <= #7 i_cmp_req;
    end
  end
endmodule : cmp_osc_model

// ==== verification/timer2_reload_capture_tb.sv ====
// self-checking bench for the reload/capture timer
`timescale 1ns/1ps
module timer2_reload_capture_tb;
  import timer2_pkg::*;
  logic i_clk;
  logic i_srst;
  bus_req_s bus;
  logic [DATA_W-1:0] o_rdata;
  logic ext_osc;
  logic cmp_out;
  logic cmp_req;
  logic o_irq;
  logic [7:0] rd;
  logic [7:0] cap;
  int n_mismatch;
  int num_checks;

  timer2_reload_capture timer2_reload_capture_inst (
    .i_clk(i_clk), .i_srst(i_srst), .i_bus(bus), .o_rdata(o_rdata),
    .i_ext_osc(ext_osc), .i_cmp_out(cmp_out), .o_irq(o_irq)
  );
  cmp_osc_model cmp_osc_model_inst (
    .i_cmp_req(cmp_req), .o_ext_osc(ext_osc), .o_cmp_out(cmp_out)
  );

  // 200 MHz system clock
  initial i_clk = 1'b0;
  always #2.5 i_clk = ~i_clk;

  task automatic complete_run();
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : complete_run

  task automatic check(input string nm, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : check

  // range compare; an unknown value never lands inside the range
  task automatic check_rng(input string nm, input logic [7:0] lo, input logic [7:0] hi,
                           input logic [7:0] got);
    num_checks++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h..%h seen %h", nm, lo, hi, got);
    end
  endtask : check_rng

  // one-cycle write strobe
  task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    bus.addr <= a;
    bus.wdata <= d;
    bus.wr <= 1'b1;
    @(posedge i_clk);
    bus.wr <= 1'b0;
  endtask : bus_wr

  // one-cycle read strobe, data taken in the cycle after only
  task automatic bus_rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clk);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge i_clk);
    bus.rd <= 1'b0;
    #1;
    d = o_rdata;
  endtask : bus_rd

  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] v;
    bus_rd(a, v);
    check(nm, exp, v);
  endtask : rd_chk

  // irq level is looked at once the last write has landed
  task automatic irq_chk(input logic exp);
    @(posedge i_clk);
    #1;
    check("o_irq", {7'h0, exp}, {7'h0, o_irq});
  endtask : irq_chk

  // hang guard, well beyond the roughly 1600 cycles the tests need
  initial begin
    #100000;
    n_mismatch++;
    complete_run();
  end

  initial begin
    bus = '0;
    cmp_req = 1'b0;
    n_mismatch = 0;
    num_checks = 0;
    i_srst = 1'b1;
    repeat (12) @(posedge i_clk);
    i_srst <= 1'b0;
    // reset values, unmapped place, unused control bit
    rd_chk("control", OFF_CONTROL, RST_CONTROL);
    rd_chk("count_low", OFF_COUNT_LOW, RST_BYTE);
    rd_chk("unmapped", 8'hc9, 8'h00);
    bus_wr(OFF_CONTROL, 8'h02);
    rd_chk("control", OFF_CONTROL, 8'h00);
    bus_wr(OFF_COUNT_HIGH, 8'ha5);
    rd_chk("count_high", OFF_COUNT_HIGH, 8'ha5);
    // 16-bit wrap loads reload value and sets both flags
    bus_wr(OFF_RELOAD_LOW, 8'h34);
    bus_wr(OFF_RELOAD_HIGH, 8'h12);
    bus_wr(OFF_CLOCK_SEL, 8'h01);
    bus_wr(OFF_COUNT_LOW, 8'hf0);
    bus_wr(OFF_COUNT_HIGH, 8'hff);
    bus_wr(OFF_CONTROL, 8'h04);
    repeat (40) @(posedge i_clk);
    rd_chk("control", OFF_CONTROL, 8'hc4);
    rd_chk("count_high", OFF_COUNT_HIGH, 8'h12);
    rd_chk("status", OFF_IRQ_STATUS, 8'h03);
    repeat (300) @(posedge i_clk);
    rd_chk("control", OFF_CONTROL, 8'hc4);
    bus_wr(OFF_IRQ_ENABLE, 8'h01);
    irq_chk(1'b1);
    bus_wr(OFF_CONTROL, 8'h00);
    irq_chk(1'b0);
    rd_chk("control", OFF_CONTROL, 8'h00);
    // status/mask path of the interrupt
    bus_wr(OFF_IRQ_ENABLE, 8'h00);
    bus_wr(OFF_IRQ_MASK, 8'h01);
    irq_chk(1'b1);
    bus_wr(OFF_IRQ_STATUS, 8'h07);
    irq_chk(1'b0);
    rd_chk("status", OFF_IRQ_STATUS, 8'h00);
    bus_wr(OFF_IRQ_MASK, 8'h00);
    // low-byte rollover alone, with its own enable
    bus_wr(OFF_COUNT_LOW, 8'hf0);
    bus_wr(OFF_COUNT_HIGH, 8'h00);
    bus_wr(OFF_IRQ_ENABLE, 8'h01);
    bus_wr(OFF_CONTROL, 8'h24);
    repeat (40) @(posedge i_clk);
    rd_chk("control", OFF_CONTROL, 8'h64);
    irq_chk(1'b1);
    // run cleared too, so the split setup below starts from a frozen count
    bus_wr(OFF_CONTROL, 8'h40);
    irq_chk(1'b0);
    bus_wr(OFF_IRQ_ENABLE, 8'h00);
    // split mode: low runs with run clear, each byte reloads from its own
    bus_wr(OFF_CLOCK_SEL, 8'h03);
    bus_wr(OFF_RELOAD_LOW, 8'hf0);
    bus_wr(OFF_RELOAD_HIGH, 8'h50);
    bus_wr(OFF_COUNT_LOW, 8'hfe);
    bus_wr(OFF_COUNT_HIGH, 8'h05);
    bus_wr(OFF_CONTROL, 8'h08);
    repeat (30) @(posedge i_clk);
    rd_chk("control", OFF_CONTROL, 8'h48);
    rd_chk("count_high", OFF_COUNT_HIGH, 8'h05);
    bus_rd(OFF_COUNT_LOW, rd);
    check_rng("count_low", 8'hf0, 8'hff, rd);
    bus_wr(OFF_COUNT_HIGH, 8'hfe);
    bus_wr(OFF_CONTROL, 8'h4c);
    repeat (30) @(posedge i_clk);
    rd_chk("control", OFF_CONTROL, 8'hcc);
    bus_rd(OFF_COUNT_HIGH, rd);
    check_rng("count_high", 8'h50, 8'h6f, rd);
    // system clock over 12: about 10 ticks in 122 cycles
    bus_wr(OFF_CLOCK_SEL, 8'h00);
    bus_wr(OFF_COUNT_LOW, 8'h00);
    bus_wr(OFF_COUNT_HIGH, 8'h00);
    bus_wr(OFF_CONTROL, 8'h04);
    repeat (120) @(posedge i_clk);
    bus_wr(OFF_CONTROL, 8'h00);
    bus_rd(OFF_COUNT_LOW, rd);
    check_rng("div12", 8'd9, 8'd11, rd);
    // external over 8: 3200 ns of a 20.6 ns oscillator is about 19 ticks
    bus_wr(OFF_COUNT_LOW, 8'h00);
    bus_wr(OFF_CONTROL, 8'h05);
    repeat (640) @(posedge i_clk);
    bus_wr(OFF_CONTROL, 8'h01);
    bus_rd(OFF_COUNT_LOW, rd);
    check_rng("ext8", 8'd17, 8'd21, rd);
    // capture on a comparator rise
    bus_wr(OFF_CLOCK_SEL, 8'h01);
    bus_wr(OFF_COUNT_LOW, 8'h00);
    bus_wr(OFF_CONTROL, 8'h14);
    repeat (50) @(posedge i_clk);
    cmp_req <= 1'b1;
    repeat (30) @(posedge i_clk);
    rd_chk("control", OFF_CONTROL, 8'h94);
    rd_chk("reload_high", OFF_RELOAD_HIGH, 8'h00);
    bus_rd(OFF_RELOAD_LOW, cap);
    check_rng("reload_low", 8'h30, 8'h48, cap);
    // no capture while split is set
    bus_wr(OFF_CONTROL, 8'h18);
    cmp_req <= 1'b0;
    repeat (20) @(posedge i_clk);
    cmp_req <= 1'b1;
    repeat (30) @(posedge i_clk);
    rd_chk("reload_low", OFF_RELOAD_LOW, cap);
    bus_rd(OFF_CONTROL, rd);
    check("high_flag", 8'h00, rd & 8'h80);
    // split high byte on the shared system/12 clock: about 10 ticks
    bus_wr(OFF_COUNT_HIGH, 8'h00);
    bus_wr(OFF_CONTROL, 8'h0c);
    repeat (120) @(posedge i_clk);
    bus_wr(OFF_CONTROL, 8'h08);
    bus_rd(OFF_COUNT_HIGH, rd);
    check_rng("split_high", 8'd9, 8'd11, rd);
    complete_run();
  end
endmodule : timer2_reload_capture_tb
